// ==== logic/csp_defs.svh ====
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// Timing figures in their own units
`define CSP_CLK_PERIOD_NS  25
`define CSP_CLK_MHZ        40
`define CSP_OSC_MHZ        12
`define CSP_EXT_MIN_MHZ    4

// Phase accumulator for the internal oscillator
`define CSP_ACC_W          16
`define CSP_ACC_SCALE      65536
`define CSP_OSC_INC_NOM    ((`CSP_OSC_MHZ * `CSP_ACC_SCALE) / `CSP_CLK_MHZ)

// External clock watchdog in internal oscillator cycles
`define CSP_TMO_W          6
`define CSP_TMO_LAST       6'h1F

// Widths and defaults of values loaded from OTP
`define CSP_TRIM_W         8
`define CSP_CFG_W          16
`define CSP_TRIM_DEF       8'h00
`define CSP_CFG_DEF        16'h0000

// Derived timebase dividers, in selected clock ticks
`define CSP_NDIV           4
`define CSP_DIV_W          8
`define CSP_DIV_CHOP       8'h10
`define CSP_DIV_BLANK      8'h04
`define CSP_DIV_STBY       8'hFF
`define CSP_DIV_STEP       8'h20

`endif

// ==== logic/csp_pkg.sv ====
`default_nettype none
package csp_pkg;

  typedef enum logic [2:0] {
    CSP_ST_HOLD = 3'b001,
    CSP_ST_LOAD = 3'b010,
    CSP_ST_RUN  = 3'b100
  } csp_state_type;

  typedef enum logic {
    CSP_SRC_INT = 1'b0,
    CSP_SRC_EXT = 1'b1
  } csp_src_type;

endpackage
`default_nettype wire

// ==== logic/csp_clk_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"

// Behaviour
// (RL1) Board ties the clock pin to ground to run from the internal oscillator.
// (RL2) Internal oscillator ticks at nominal 12 MHz, trimmed by an OTP value.
// (RL3) First rising edge on the external clock pin selects the external source.
// (RL4) No external edge within 32 internal cycles reverts to the internal oscillator.
// (RL5) External source runs 8 to 13.4 MHz, never above 16 MHz.
// (RL6) External clocks down to 4 MHz keep the block running.
// (RL7) Power-on loads defaults, then captures trim and configuration from OTP.
// (RL8) Any monitored supply dropping returns everything to power-on defaults; the oscillator accumulator and its ticks keep running.
// (RL9) While the IO supply is off, all digital inputs are driven low; here only the test model drives the clock pin low, OTP inputs are not.
// (RL10) Chopper, blank, standstill and step timing all count selected clock ticks.
// (RL11) Source changes only deliver whole ticks, never truncated pulses.
module csp_clk_sel (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ext_clk_pin,
  input  wire logic                    motor_supply_rail_ok,
  input  wire logic                    regulator_output_rail_ok,
  input  wire logic                    io_supply_rail_ok,
  input  wire logic [`CSP_TRIM_W-1:0]  otp_trim,
  input  wire logic [`CSP_CFG_W-1:0]   otp_cfg,
  output var  csp_pkg::csp_src_type    clk_src,
  output logic                         sel_tick,
  output logic                         init_done,
  output logic [`CSP_TRIM_W-1:0]       trim_out,
  output logic [`CSP_CFG_W-1:0]        cfg_out,
  output logic                         chop_tick,
  output logic                         blank_tick,
  output logic                         standstill_tick,
  output logic                         step_tick
);
  import csp_pkg::*;

  localparam logic [`CSP_DIV_W-1:0] DIV_TAB [`CSP_NDIV] = '{
    `CSP_DIV_CHOP, `CSP_DIV_BLANK, `CSP_DIV_STBY, `CSP_DIV_STEP};
  localparam logic [`CSP_ACC_W-1:0] INC_NOM = `CSP_ACC_W'(`CSP_OSC_INC_NOM);

  csp_state_type              state_r;
  csp_src_type                src_r;
  csp_src_type                src_nxt;
  logic [3:0]                 sup_s1_r;
  logic [3:0]                 sup_s2_r;
  logic                       ext_s3_r;
  logic                       ext_edge;
  logic                       ext_rise;
  logic                       ext_edge_r;
  logic                       osc_keep;
  logic                       sup_ok;
  logic [`CSP_ACC_W:0]        acc_sum;
  logic [`CSP_ACC_W-1:0]      acc_r;
  logic [`CSP_ACC_W-1:0]      inc;
  logic                       osc_tick;
  logic [`CSP_TMO_W-1:0]      tmo_r;
  logic                       tmo_hit;
  logic                       tick_nxt;
  logic                       sel_tick_r;
  logic                       done_r;
  logic [`CSP_TRIM_W-1:0]     trim_r;
  logic [`CSP_CFG_W-1:0]      cfg_r;
  logic [`CSP_NDIV-1:0]       div_tick_r;

  // Pin and supply monitors through two flip-flops; bit 0 is the clock pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_s1_r <= 4'h0;
      sup_s2_r <= 4'h0;
      ext_s3_r <= 1'b0;
      ext_edge_r <= 1'b0;
    end else begin
      sup_s1_r <= {motor_supply_rail_ok, regulator_output_rail_ok, io_supply_rail_ok,
                   ext_clk_pin};
      sup_s2_r <= sup_s1_r;
      ext_s3_r <= sup_s2_r[0];
      ext_edge_r <= ext_rise;
    end
  end

  assign sup_ok   = &sup_s2_r[3:1];                             // RL8
  // Extra edge stage lets the tick logic see a takeover one cycle ahead
  assign ext_rise = sup_s2_r[0] & ~ext_s3_r;
  assign ext_edge = ext_edge_r;

  // Power-on sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CSP_ST_HOLD;
    end else if (!sup_ok) begin
      state_r <= CSP_ST_HOLD;                                   // RL8
    end else begin
      case (state_r)
        CSP_ST_HOLD: state_r <= CSP_ST_LOAD;
        CSP_ST_LOAD: state_r <= CSP_ST_RUN;
        CSP_ST_RUN:  state_r <= CSP_ST_RUN;
        default:     state_r <= CSP_ST_HOLD;
      endcase
    end
  end

  // Defaults, then OTP capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_r <= `CSP_TRIM_DEF;
      cfg_r  <= `CSP_CFG_DEF;
      done_r <= 1'b0;
    end else if (!sup_ok || state_r == CSP_ST_HOLD) begin
      trim_r <= `CSP_TRIM_DEF;                                  // RL7
      cfg_r  <= `CSP_CFG_DEF;
      done_r <= 1'b0;
    end else if (state_r == CSP_ST_LOAD) begin
      trim_r <= otp_trim;                                       // RL7
      cfg_r  <= otp_cfg;
      done_r <= 1'b1;
    end
  end

  // Trimmed internal oscillator as a tick train
  assign inc      = INC_NOM + {{(`CSP_ACC_W-`CSP_TRIM_W){trim_r[`CSP_TRIM_W-1]}}, trim_r};
  assign acc_sum  = {1'b0, acc_r} + {1'b0, inc};                // RL2
  assign osc_tick = acc_sum[`CSP_ACC_W];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_sum[`CSP_ACC_W-1:0];
    end
  end

  // Source selection with external clock watchdog
  assign tmo_hit = osc_tick && (tmo_r == `CSP_TMO_LAST) && !ext_edge;

  always_comb begin
    src_nxt = src_r;
    if (state_r != CSP_ST_RUN || !sup_ok) begin
      src_nxt = CSP_SRC_INT;                                    // RL8
    end else if (src_r == CSP_SRC_INT && ext_edge) begin
      src_nxt = CSP_SRC_EXT;                                    // RL3
    end else if (src_r == CSP_SRC_EXT && tmo_hit) begin
      src_nxt = CSP_SRC_INT;                                    // RL4
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= CSP_SRC_INT;
    end else begin
      src_r <= src_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_r <= '0;
    end else if (src_r != CSP_SRC_EXT || ext_edge || tmo_hit) begin
      tmo_r <= '0;                                              // RL6
    end else if (osc_tick) begin
      tmo_r <= tmo_r + `CSP_TMO_W'(1);                          // RL4
    end
  end

  // Whole ticks only: each tick is one full edge of the chosen source
  // Osc tick dropped right after a tick or just before an external takeover
  assign osc_keep = !sel_tick_r && !(ext_rise && sup_ok && state_r != CSP_ST_HOLD);  // RL11
  assign tick_nxt = (src_nxt == CSP_SRC_EXT) ? ext_edge : (osc_tick && osc_keep);    // RL11

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_tick_r <= 1'b0;
    end else begin
      sel_tick_r <= tick_nxt;
    end
  end

  // Derived timebases
  genvar gi;
  generate
    for (gi = 0; gi < `CSP_NDIV; gi++) begin : g_div
      logic [`CSP_DIV_W-1:0] cnt_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r            <= '0;
          div_tick_r[gi]   <= 1'b0;
        end else if (state_r != CSP_ST_RUN) begin
          cnt_r            <= '0;
          div_tick_r[gi]   <= 1'b0;
        end else if (tick_nxt) begin
          if (cnt_r == DIV_TAB[gi] - `CSP_DIV_W'(1)) begin
            cnt_r          <= '0;
            div_tick_r[gi] <= 1'b1;                             // RL10
          end else begin
            cnt_r          <= cnt_r + `CSP_DIV_W'(1);
            div_tick_r[gi] <= 1'b0;
          end
        end else begin
          div_tick_r[gi]   <= 1'b0;
        end
      end
    end
  endgenerate

  assign clk_src         = src_r;
  assign sel_tick        = sel_tick_r;
  assign init_done       = done_r;
  assign trim_out        = trim_r;
  assign cfg_out         = cfg_r;
  assign chop_tick       = div_tick_r[0];
  assign blank_tick      = div_tick_r[1];
  assign standstill_tick = div_tick_r[2];
  assign step_tick       = div_tick_r[3];

  property p_osc_rate;
    @(posedge clk) disable iff (!rst_n)
      osc_tick |=> !osc_tick ##[1:4] osc_tick;
  endproperty
  a_osc_rate: assert property (p_osc_rate) else $error("oscillator tick spacing wrong"); // RL2

  property p_switch_ext;
    @(posedge clk) disable iff (!rst_n)
      (state_r == CSP_ST_RUN && sup_ok && src_r == CSP_SRC_INT && ext_edge)
        |=> (src_r == CSP_SRC_EXT && sel_tick_r);
  endproperty
  a_switch_ext: assert property (p_switch_ext) else $error("no switch to external"); // RL3

  property p_revert;
    @(posedge clk) disable iff (!rst_n)
      (src_r == CSP_SRC_EXT && tmo_r == `CSP_TMO_LAST && osc_tick && !ext_edge)
        |=> src_r == CSP_SRC_INT;
  endproperty
  a_revert: assert property (p_revert) else $error("no revert after timeout"); // RL4

  property p_hold_ext;
    @(posedge clk) disable iff (!rst_n)
      (state_r == CSP_ST_RUN && sup_ok && src_r == CSP_SRC_EXT && !tmo_hit)
        |=> src_r == CSP_SRC_EXT;
  endproperty
  a_hold_ext: assert property (p_hold_ext) else $error("early revert to internal"); // RL6

  property p_load;
    @(posedge clk) disable iff (!rst_n)
      (state_r == CSP_ST_LOAD && sup_ok) |=> (done_r && trim_r == $past(otp_trim));
  endproperty
  a_load: assert property (p_load) else $error("OTP trim not captured"); // RL7

  property p_supply;
    @(posedge clk) disable iff (!rst_n)
      !sup_ok |=> (state_r == CSP_ST_HOLD && !done_r && src_r == CSP_SRC_INT
                   && cfg_r == `CSP_CFG_DEF);
  endproperty
  a_supply: assert property (p_supply) else $error("supply drop did not reset"); // RL8

  property p_chop_tick;
    @(posedge clk) disable iff (!rst_n)
      chop_tick |-> sel_tick_r;
  endproperty
  a_chop_tick: assert property (p_chop_tick) else $error("chopper tick off timebase"); // RL10

  property p_whole_tick;
    @(posedge clk) disable iff (!rst_n)
      (sel_tick_r && src_r == CSP_SRC_EXT) |-> $past(ext_edge);
  endproperty
  a_whole_tick: assert property (p_whole_tick) else $error("external tick without edge"); // RL11

  property p_one_tick;
    @(posedge clk) disable iff (!rst_n)
      sel_tick_r |=> !sel_tick_r;
  endproperty
  a_one_tick: assert property (p_one_tick) else $error("ticks back to back"); // RL11

  c_to_ext: cover property (@(posedge clk) disable iff (!rst_n)
    src_r == CSP_SRC_INT ##1 src_r == CSP_SRC_EXT);
  c_to_int: cover property (@(posedge clk) disable iff (!rst_n)
    src_r == CSP_SRC_EXT ##1 src_r == CSP_SRC_INT);
  c_reload: cover property (@(posedge clk) disable iff (!rst_n)
    done_r ##1 !done_r ##[1:10] done_r);
endmodule
`default_nettype wire

// ==== verif/csp_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module csp_src_model (
  input  wire logic        ext_en,
  input  wire logic        io_on,
  input  wire logic        motor_on,
  input  wire logic [15:0] half_ns,
  output logic             ext_clk_pin,
  output logic             motor_supply_rail_ok,
  output logic             regulator_output_rail_ok,
  output logic             io_supply_rail_ok
);
  // Regulator rail cannot be cycled apart from the motor rail
  assign motor_supply_rail_ok     = motor_on;
  assign regulator_output_rail_ok = motor_on;
  assign io_supply_rail_ok        = io_on;
  initial ext_clk_pin = 1'b0;
  always begin
    #(half_ns);
    if (ext_en && io_on) begin
      ext_clk_pin = ~ext_clk_pin;
    end else begin
      ext_clk_pin = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/clock_source_select_and_por_init_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH %0t compare failed", $time); end end
module clock_source_select_and_por_init_tb;
  import csp_pkg::*;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   ext_en = 1'b0;
  logic                   io_on = 1'b1;
  logic                   motor_on = 1'b1;
  logic [15:0]            half_ns = 16'h0032;
  logic [`CSP_TRIM_W-1:0] otp_trim = 8'h00;
  logic [`CSP_CFG_W-1:0]  otp_cfg = 16'h5A3C;
  wire logic              ext_clk_pin, m_ok, r_ok, io_ok;
  csp_src_type            clk_src;
  logic                   sel_tick, init_done, chop_tick, blank_tick, stby_tick, step_tick;
  logic [`CSP_TRIM_W-1:0] trim_out;
  logic [`CSP_CFG_W-1:0]  cfg_out;
  logic                   prev_tick = 1'b0;
  int                     mismatches = 0;
  int                     checks = 0;
  int                     s, c, b, st, sp;

  csp_src_model ext (.ext_en(ext_en), .io_on(io_on), .motor_on(motor_on),
    .half_ns(half_ns), .ext_clk_pin(ext_clk_pin), .motor_supply_rail_ok(m_ok),
    .regulator_output_rail_ok(r_ok), .io_supply_rail_ok(io_ok));
  csp_clk_sel uut (.clk(clk), .rst_n(rst_n), .ext_clk_pin(ext_clk_pin),
    .motor_supply_rail_ok(m_ok), .regulator_output_rail_ok(r_ok),
    .io_supply_rail_ok(io_ok), .otp_trim(otp_trim), .otp_cfg(otp_cfg),
    .clk_src(clk_src), .sel_tick(sel_tick), .init_done(init_done),
    .trim_out(trim_out), .cfg_out(cfg_out), .chop_tick(chop_tick),
    .blank_tick(blank_tick), .standstill_tick(stby_tick), .step_tick(step_tick));

  always #12.5 clk = ~clk;

  // Selected ticks never come back to back
  always @(posedge clk) begin
    if (rst_n && prev_tick && sel_tick) `CHK(1'b1, 1'b0)
    prev_tick <= sel_tick;
  end

  function automatic bit near(input int a, input int e);
    return (a >= e - 1) && (a <= e + 1);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic count(input int n);
    s = 0; c = 0; b = 0; st = 0; sp = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      s += sel_tick; c += chop_tick; b += blank_tick; st += stby_tick; sp += step_tick;
    end
  endtask

  task automatic t_por();
    cyc(12);
    rst_n <= 1'b1;
    cyc(6);
    `CHK(init_done, 1'b1)
    `CHK(cfg_out, 16'h5A3C)
    `CHK(trim_out, 8'h00)
    `CHK(clk_src, CSP_SRC_INT)
  endtask

  task automatic t_int();
    count(1800);
    `CHK(s == 539 || s == 540, 1'b1)
    `CHK(near(c, s / 16) && near(b, s / 4), 1'b1)
    `CHK(near(st, s / 255) && near(sp, s / 32), 1'b1)
  endtask

  task automatic t_ext();
    ext_en <= 1'b1;
    cyc(8);
    `CHK(clk_src, CSP_SRC_EXT)
    count(400);
    `CHK(near(s, 100) && near(c, 6) && near(b, 25), 1'b1)
    half_ns <= 16'h007D;
    count(400);
    `CHK(near(s, 40), 1'b1)
    `CHK(clk_src, CSP_SRC_EXT)
  endtask

  task automatic t_tmo();
    ext_en <= 1'b0;
    cyc(85);
    `CHK(clk_src, CSP_SRC_EXT)
    cyc(34);
    `CHK(clk_src, CSP_SRC_INT)
  endtask

  task automatic t_supply(input bit io_rail);
    ext_en <= 1'b1;
    cyc(20);
    `CHK(clk_src, CSP_SRC_EXT)
    if (io_rail) io_on <= 1'b0;
    else motor_on <= 1'b0;
    cyc(5);
    `CHK(init_done, 1'b0)
    `CHK(clk_src, CSP_SRC_INT)
    `CHK(cfg_out, 16'h0000)
    otp_cfg <= io_rail ? 16'hC3A5 : 16'h0F1E;
    otp_trim <= 8'h05;
    cyc(4);
    io_on <= 1'b1;
    motor_on <= 1'b1;
    ext_en <= 1'b0;
    cyc(8);
    `CHK(init_done, 1'b1)
    `CHK(cfg_out, io_rail ? 16'hC3A5 : 16'h0F1E)
    `CHK(trim_out, 8'h05)
  endtask

  task automatic finish_test();
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    mismatches++;
    finish_test();
  end

  initial begin
    t_por();
    t_int();
    t_ext();
    t_tmo();
    t_supply(1'b1);
    t_supply(1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
